// ===== design/pwm_phase_regs.svh
`ifndef PWM_PHASE_REGS_SVH
`define PWM_PHASE_REGS_SVH
`define CLK_FREQ_HZ      10000000
`define NUM_CH           4
`define CUR_W            12
`define PER_W            12
`define STRAP_CYCLES     12'h008
`define MIN_PERIOD       12'h006
`endif

// ===== design/pwm_phase_pkg.sv
package pwm_phase_pkg;
  typedef enum logic [0:0] {
    ST_STRAP = 1'b0,
    ST_RUN   = 1'b1
  } mode_t;

  typedef struct packed {
    mode_t           mode;
    logic [11:0]     strap_cnt;
    logic [2:0]      nch;
    logic [11:0]     period;
    logic [11:0]     third;
    logic [11:0]     cnt;
    logic [3:0]      out;
    logic [3:0]      win;
    logic [3:0][11:0] fcnt;
    logic [3:0][11:0] wcnt;
    logic [3:0][11:0] track;
    logic [3:0][11:0] hold;
    logic [11:0]     avg;
  } state_t;
endpackage : pwm_phase_pkg

// ===== design/multiphase_pwm_phase_timing.sv
`timescale 1ns/1ns
`default_nettype none
`include "pwm_phase_regs.svh"

module multiphase_pwm_phase_timing (
  // Clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RESET,
  // Switching period in core clock cycles, set by the frequency resistor
  input  wire logic [11:0]       FREQ_SET_PIN,
  // Comparator: corrected error level has crossed each channel's ramp
  input  wire logic [3:0]        RAMP_CROSS,
  // Sensed current per channel
  input  wire logic [3:0][11:0]  CURRENT_SENSE_INPUT,
  // Phase outputs; 3 and 4 are two-way for strap sensing
  output logic                   PHASE_OUT_1,
  output logic                   PHASE_OUT_2,
  input  wire logic              PHASE_OUT_3_IN,
  output logic                   PHASE_OUT_3_OUT,
  output logic                   PHASE_OUT_3_OE,
  input  wire logic              PHASE_OUT_4_IN,
  output logic                   PHASE_OUT_4_OUT,
  output logic                   PHASE_OUT_4_OE,
  // Sample and hold results
  output logic [3:0]             SAMPLE_WINDOW,
  output logic [3:0][11:0]       SAMPLED_CURRENT,
  output logic [11:0]            CYCLE_AVERAGE_CURRENT,
  output logic [2:0]             ACTIVE_CHANNELS,
  output logic                   RUNNING
);

  pwm_phase_pkg::state_t s_r;
  pwm_phase_pkg::state_t s_nxt;

  logic [3:0]       active;
  logic [3:0]       at_term;
  logic [3:0]       off_done;
  logic [3:0][11:0] term_off;
  logic [3:0][13:0] prod;
  logic [13:0]      sum;
  logic [2:0]       nsel;
  logic [11:0]      per_in;

  // Operating sequence
  //   Reset clears every phase output, window and held sample, and
  //   releases phase outputs 3 and 4 so that their straps can be read.
  //   The strap phase then runs for a fixed number of clocks; on its
  //   last clock the straps and the period input are latched together.
  //   From then on the channel count and period stay fixed until the
  //   next reset, so a strap that moves later cannot reshape the phases.
  //
  // Termination clock
  //   One counter runs from zero to the period minus one. Zero is the
  //   termination of phase output 1 and so the start of every cycle.
  //   Channel k terminates at floor(period * k / count), which gives
  //   quarter, half or third spacing from the same divider.
  //   Periods below the minimum are clamped, so a third of the period
  //   is never zero and the forced off-time always exists.
  //
  // Per-channel sequence
  //   A high output falls at its termination; the forced off counter
  //   and the sample window both load a third of the period there.
  //   While the off counter runs the comparator is ignored. Once it
  //   reaches zero the first comparator crossing raises the output,
  //   one clock later. A termination and a crossing in one clock
  //   resolve to low, so a pulse never runs into the next cycle.
  //   An output that is still low at its termination starts no window:
  //   there was no conduction interval worth sampling.
  //
  // Sample and hold
  //   The window follows the sense input and freezes it on its last
  //   clock. The frozen value stands until the next window ends, a
  //   full switching cycle later in steady state.
  //   The average is formed from the held values one clock later and
  //   truncates toward zero.
  //
  // Inactive channels
  //   Their outputs, windows and held samples stay at zero, so they
  //   add nothing to the average. Outputs 3 and 4 keep their drivers
  //   off while strapped, so a tie to the supply is never fought.
  //
  // Example: period 12 with four channels
  //   Terminations fall at counts 0, 3, 6 and 9. A third of the
  //   period is 4, so each output stays low for at least 4 clocks
  //   and each window is high for exactly 4 clocks after its fall.
  //   With the comparator held high every output rises on the first
  //   clock after its off-time and falls again at its next termination.

  // Per-channel termination point and activity
  genvar g;
  for (g = 0; g < 4; g++) begin : g_chan
    assign active[g]   = RUNNING && (3'(g) < s_r.nch);
    assign prod[g]     = 14'(s_r.period) * 14'(g);
    assign term_off[g] = 12'(prod[g] / 14'(s_r.nch));
    assign at_term[g]  = RUNNING && (s_r.cnt == term_off[g]);
    assign off_done[g] = (s_r.fcnt[g] == 12'h000);
  end

  always_comb begin
    s_nxt  = s_r;
    sum    = 14'h0000;
    nsel   = 3'h4;
    per_in = FREQ_SET_PIN;
    case (s_r.mode)
      pwm_phase_pkg::ST_STRAP: begin
        // Outputs 3 and 4 are released so the straps can be read
        s_nxt.strap_cnt = s_r.strap_cnt + 12'h001;
        if (s_r.strap_cnt == `STRAP_CYCLES - 12'h001) begin
          if (PHASE_OUT_3_IN && PHASE_OUT_4_IN) begin
            nsel = 3'h1;
          end else if (PHASE_OUT_3_IN) begin
            nsel = 3'h2;
          end else if (PHASE_OUT_4_IN) begin
            nsel = 3'h3;
          end else begin
            nsel = 3'h4;
          end
          if (per_in < `MIN_PERIOD) begin
            per_in = `MIN_PERIOD;
          end
          s_nxt.nch    = nsel;
          s_nxt.period = per_in;
          s_nxt.third  = per_in / 12'h003;
          s_nxt.cnt    = 12'h000;
          s_nxt.mode   = pwm_phase_pkg::ST_RUN;
        end
      end
      pwm_phase_pkg::ST_RUN: begin
        // Termination clock: one period count per switching cycle
        if (s_r.cnt == s_r.period - 12'h001) begin
          s_nxt.cnt = 12'h000;
        end else begin
          s_nxt.cnt = s_r.cnt + 12'h001;
        end
        for (int k = 0; k < 4; k++) begin
          if (!active[k]) begin
            s_nxt.out[k]   = 1'b0;
            s_nxt.win[k]   = 1'b0;
            s_nxt.fcnt[k]  = 12'h000;
            s_nxt.hold[k]  = 12'h000;
          end else begin
            if (s_r.fcnt[k] != 12'h000) begin
              s_nxt.fcnt[k] = s_r.fcnt[k] - 12'h001;
            end
            // Sample window tracks the input, then freezes the value
            if (s_r.win[k]) begin
              s_nxt.track[k] = CURRENT_SENSE_INPUT[k];
              if (s_r.wcnt[k] == 12'h001) begin
                s_nxt.win[k]  = 1'b0;
                s_nxt.hold[k] = CURRENT_SENSE_INPUT[k];
              end
              s_nxt.wcnt[k] = s_r.wcnt[k] - 12'h001;
            end
            if (at_term[k]) begin
              // Termination wins over a crossing in the same cycle
              s_nxt.out[k] = 1'b0;
              if (s_r.out[k]) begin
                s_nxt.fcnt[k]  = s_r.third;
                s_nxt.win[k]   = 1'b1;
                s_nxt.wcnt[k]  = s_r.third;
                s_nxt.track[k] = CURRENT_SENSE_INPUT[k];
              end
            end else if (!s_r.out[k] && off_done[k] && RAMP_CROSS[k]) begin
              s_nxt.out[k] = 1'b1;
            end
          end
          if (active[k]) begin
            sum = sum + 14'(s_r.hold[k]);
          end
        end
        s_nxt.avg = 12'(sum / 14'(s_r.nch));
      end
      default: begin
        s_nxt.mode = pwm_phase_pkg::ST_STRAP;
      end
    endcase
  end

  // Synchronous reset; the count reads four until the straps are latched
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      s_r      <= '0;
      s_r.mode <= pwm_phase_pkg::ST_STRAP;
      s_r.nch  <= 3'h4;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Output stage
  //   Phase levels, windows and held samples come straight from the
  //   state register; only RUNNING and the output enables are decoded here.
  assign RUNNING               = (s_r.mode == pwm_phase_pkg::ST_RUN);
  assign PHASE_OUT_1           = s_r.out[0];
  assign PHASE_OUT_2           = s_r.out[1];
  assign PHASE_OUT_3_OUT       = s_r.out[2];
  assign PHASE_OUT_4_OUT       = s_r.out[3];
  // Strapped pins are never driven against the supply
  assign PHASE_OUT_3_OE        = RUNNING && (s_r.nch > 3'h2);
  assign PHASE_OUT_4_OE        = RUNNING && (s_r.nch > 3'h3);
  assign SAMPLE_WINDOW         = s_r.win;
  assign SAMPLED_CURRENT       = s_r.hold;
  assign CYCLE_AVERAGE_CURRENT = s_r.avg;
  assign ACTIVE_CHANNELS       = s_r.nch;

endmodule : multiphase_pwm_phase_timing

`default_nettype wire

// ===== sim/pwm_phase_properties.sv
`timescale 1ns/1ns
`default_nettype none
module pwm_phase_checker (
  input wire logic                  CORE_CLK, RESET, PHASE_OUT_1, PHASE_OUT_2, RUNNING,
  input wire logic                  PHASE_OUT_3_OE, PHASE_OUT_4_OE,
  input wire logic [3:0]            RAMP_CROSS, SAMPLE_WINDOW,
  input wire logic [3:0][11:0]      SAMPLED_CURRENT,
  input wire logic [2:0]            ACTIVE_CHANNELS
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  sequence fall_one; $fell(PHASE_OUT_1); endsequence
  sequence win_open; $rose(SAMPLE_WINDOW[0]); endsequence
  off_time_a: assert property (fall_one |-> !PHASE_OUT_1 [*4])
    else $error("off short");
  win_start_a: assert property (fall_one |-> win_open) else $error("no window");
  win_len_a: assert property (win_open |-> SAMPLE_WINDOW[0] [*4] ##1 !SAMPLE_WINDOW[0])
    else $error("window length");
  hold_keep_a: assert property (
    !$stable(SAMPLED_CURRENT[0]) |-> $fell(SAMPLE_WINDOW[0])) else $error("hold moved");
  high_stay_a: assert property (PHASE_OUT_1 |=> PHASE_OUT_1 || $rose(SAMPLE_WINDOW[0]))
    else $error("early low");
  rise_cause_a: assert property ($rose(PHASE_OUT_1) |-> $past(RAMP_CROSS[0]))
    else $error("rise uncaused");
  single_ch_a: assert property (ACTIVE_CHANNELS == 3'h1 |->
    !(PHASE_OUT_2 | PHASE_OUT_3_OE | PHASE_OUT_4_OE)) else $error("extra output");
  count_hold_a: assert property (RUNNING |=> $stable(ACTIVE_CHANNELS))
    else $error("count moved");
endmodule : pwm_phase_checker
bind multiphase_pwm_phase_timing pwm_phase_checker u_pwm_phase_checker (.CORE_CLK, .RESET,
  .PHASE_OUT_1, .PHASE_OUT_2, .RUNNING, .PHASE_OUT_3_OE, .PHASE_OUT_4_OE, .RAMP_CROSS,
  .SAMPLE_WINDOW, .SAMPLED_CURRENT, .ACTIVE_CHANNELS);
`default_nettype wire

// ===== sim/phase_driver_model.sv
`timescale 1ns/1ns
`default_nettype none
module phase_driver_model (
  input wire logic           clk, rst, tie3, tie4, p1, p2, o3, e3, o4, e4,
  output logic               w3, w4,
  output logic [3:0][15:0]   fall_at,
  output logic [3:0]         fell
);
  logic [15:0] now = 16'h0;
  logic [3:0]  prev = 4'h0;
  wire logic [3:0] w = {w4, w3, p2, p1};
  // Released, unstrapped pins sit on the pull-down
  assign w3 = tie3 | (e3 & o3);
  assign w4 = tie4 | (e4 & o4);
  always @(posedge clk) begin
    now <= now + 16'h1;
    prev <= w;
    for (int k = 0; k < 4; k++) begin
      if (rst) fell[k] <= 1'b0;
      else if (prev[k] & !w[k]) begin
        fell[k] <= 1'b1;
        fall_at[k] <= now;
      end
    end
  end
endmodule : phase_driver_model
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 0, rst = 1, tie3 = 0, tie4 = 0, p1, p2, o3, e3, o4, e4, w3, w4, run;
  logic [3:0] ramp = 4'h0, win, fell;
  logic [3:0][11:0] current_sense_input = {12'h040, 12'h031, 12'h022, 12'h013}, held;
  logic [11:0] avg;
  logic [2:0] nact;
  logic [3:0][15:0] fat;
  int error_cnt = 0, num_checks = 0;
  always #50 clk = ~clk;
  multiphase_pwm_phase_timing u_multiphase_pwm_phase_timing (.CORE_CLK(clk), .RESET(rst),
    .FREQ_SET_PIN(12'h00C), .RAMP_CROSS(ramp), .CURRENT_SENSE_INPUT(current_sense_input), .PHASE_OUT_1(p1),
    .PHASE_OUT_2(p2), .PHASE_OUT_3_IN(w3), .PHASE_OUT_3_OUT(o3), .PHASE_OUT_3_OE(e3),
    .PHASE_OUT_4_IN(w4), .PHASE_OUT_4_OUT(o4), .PHASE_OUT_4_OE(e4), .SAMPLE_WINDOW(win),
    .SAMPLED_CURRENT(held), .CYCLE_AVERAGE_CURRENT(avg), .ACTIVE_CHANNELS(nact), .RUNNING(run));
  phase_driver_model u_phase_driver_model (.clk, .rst, .tie3, .tie4, .p1, .p2, .o3, .e3,
    .o4, .e4, .w3, .w4, .fall_at(fat), .fell);
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic restart(logic s3, logic s4, logic [3:0] rc);
    @(posedge clk);
    #10 {rst, tie3, tie4, ramp} = {1'b1, s3, s4, rc};
    repeat (5) @(posedge clk);
    #10 rst = 0;
    check("running", 16'h0, 16'(run));
    check("reset channels", 16'h4, 16'(nact));
  endtask : restart
  task automatic run_mode(logic s3, logic s4, int n);
    logic [15:0] sum = 16'h0;
    restart(s3, s4, 4'hF);
    repeat (60) @(posedge clk);
    #10 check("channels", 16'(n), 16'(nact));
    check("running", 16'h1, 16'(run));
    for (int k = 0; k < 4; k++) begin
      check("fell", 16'(k < n), 16'(fell[k]));
      check("held", k < n ? 16'(current_sense_input[k]) : 16'h0, 16'(held[k]));
      if (k < n) begin
        check("spacing", 16'(12 * k / n), (fat[k] + 16'h78 - fat[0]) % 16'hC);
        sum += 16'(current_sense_input[k]);
      end
    end
    check("average", sum / 16'(n), 16'(avg));
    $display("mode %0d done", n);
  endtask : run_mode
  task automatic ramp_idle();
    restart(1'b0, 1'b0, 4'h0);
    repeat (40) @(posedge clk);
    #10 check("idle fell", 16'h0, 16'(fell));
    ramp = 4'h1;
    repeat (3) @(posedge clk);
    #10 check("rise", 16'h1, 16'(p1));
    $display("ramp idle done");
  endtask : ramp_idle
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clk);
    run_mode(1'b0, 1'b0, 4);
    run_mode(1'b1, 1'b0, 2);
    run_mode(1'b0, 1'b1, 3);
    run_mode(1'b1, 1'b1, 1);
    ramp_idle();
    conclude();
  end
endmodule : tb
`default_nettype wire
